// ===== simreg_pkg.sv
/*
  Shared constants and carrier types for the regulator configuration bank:
  register offsets, field positions, reset values of reserved bits and the
  decode figures for current limits and target voltages.
  Assumes an 8-bit register address and 8-bit data from the serial decoder.
*/
package simreg_pkg;

  // register offsets
  localparam logic [7:0] SIMREG_OFS_CH2_CTRL = 8'h2e;
  localparam logic [7:0] SIMREG_OFS_TOP_CFG = 8'h2f;
  localparam logic [7:0] SIMREG_OFS_PEAK_LIM = 8'h30;
  localparam logic [7:0] SIMREG_OFS_CH0_ALT_V = 8'h31;

  // field positions, channel 2 control
  localparam int SIMREG_CH2_RESERVED_POS = 7;
  localparam int SIMREG_CH2_MODE_POS = 6;
  localparam int SIMREG_CH2_DISCH_POS = 3;
  localparam int SIMREG_CH2_EN_LSB = 0;
  // field positions, top config
  localparam int SIMREG_TOP_CHGMODE_POS = 7;
  localparam int SIMREG_TOP_DRV_LSB = 0;
  // field positions, peak limits
  localparam int SIMREG_LIM_CHG_LSB = 6;
  localparam int SIMREG_LIM_CH2_LSB = 4;
  localparam int SIMREG_LIM_CH1_LSB = 2;
  localparam int SIMREG_LIM_CH0_LSB = 0;
  // field positions, channel 0 alternate voltage
  localparam int SIMREG_ALT_RESERVED_POS = 7;
  localparam int SIMREG_ALT_CODE_LSB = 0;

  // reset values of reserved bits
  localparam logic SIMREG_RESERVED_RST = 1'b0;
  localparam logic [1:0] SIMREG_UNUSED2_RST = 2'h0;
  localparam logic [4:0] SIMREG_UNUSED5_RST = 5'h00;

  // enable field codes
  localparam logic [2:0] SIMREG_EN_SLOT_MAX = 3'h3;
  localparam logic [2:0] SIMREG_EN_FORCE_ON_MIN = 3'h6;

  // charging channel peak limit in mA per code
  localparam logic [11:0] SIMREG_CHG_MA0 = 12'h7d0; // 2000
  localparam logic [11:0] SIMREG_CHG_MA1 = 12'h5dc; // 1500
  localparam logic [11:0] SIMREG_CHG_MA2 = 12'h3e8; // 1000
  localparam logic [11:0] SIMREG_CHG_MA3 = 12'h1f4; // 500
  // output channel peak limit in mA per code
  localparam logic [11:0] SIMREG_OUT_MA0 = 12'h3e8; // 1000
  localparam logic [11:0] SIMREG_OUT_MA1 = 12'h2ee; // 750
  localparam logic [11:0] SIMREG_OUT_MA2 = 12'h1f4; // 500
  localparam logic [11:0] SIMREG_OUT_MA3 = 12'h14d; // 333

  // target voltage transfer, mV
  localparam logic [12:0] SIMREG_V_BASE_MV = 13'h01f4; // 500
  localparam logic [12:0] SIMREG_V_FINE_STEP_MV = 13'h0019; // 25
  localparam logic [12:0] SIMREG_V_KNEE_MV = 13'h06a4; // 1700
  localparam logic [12:0] SIMREG_V_COARSE_STEP_MV = 13'h0032; // 50
  localparam logic [12:0] SIMREG_V_MAX_MV = 13'h157c; // 5500
  localparam logic [6:0] SIMREG_V_KNEE_CODE = 7'h30;
  localparam logic [6:0] SIMREG_V_CLAMP_CODE = 7'h7c;

  typedef struct packed {
    logic reserved_bit;
    logic buck_only;
    logic [1:0] unused;
    logic discharge_on;
    logic [2:0] slot_select;
  } simreg_ch2_ctrl_t;

  typedef struct packed {
    logic charge_buck_only;
    logic [4:0] unused;
    logic [1:0] drive_trim;
  } simreg_top_cfg_t;

  typedef struct packed {
    logic [1:0] charge;
    logic [1:0] ch2;
    logic [1:0] ch1;
    logic [1:0] ch0;
  } simreg_peak_lim_t;

  typedef struct packed {
    logic reserved_bit;
    logic [6:0] code;
  } simreg_alt_v_t;

  // factory image loaded at reset
  typedef struct packed {
    simreg_ch2_ctrl_t ch2_ctrl;
    simreg_top_cfg_t top_cfg;
    simreg_peak_lim_t peak_lim;
    simreg_alt_v_t alt_v;
  } simreg_otp_t;

endpackage

// ===== simreg_vdecode.sv
/*
  Target-voltage decoder: 7-bit code to millivolts, piecewise linear.
  Assumes a stable code input; output is combinational, registered by caller.
*/
`timescale 1ns/1ps
`default_nettype none
module simreg_vdecode
  import simreg_pkg::*;
(
  input wire logic [6:0] code, // voltage code
  output logic [12:0] millivolts // decoded target
);

  logic [12:0] code_w;

  always_comb begin
    code_w = {6'h00, code};
    if (code >= SIMREG_V_CLAMP_CODE) begin
      millivolts = SIMREG_V_MAX_MV;
    end else if (code >= SIMREG_V_KNEE_CODE) begin
      millivolts = 13'(SIMREG_V_KNEE_MV
        + SIMREG_V_COARSE_STEP_MV * (code_w - {6'h00, SIMREG_V_KNEE_CODE}));
    end else begin
      millivolts = 13'(SIMREG_V_BASE_MV + SIMREG_V_FINE_STEP_MV * code_w);
    end
  end

endmodule
`default_nettype wire

// ===== simreg_regs.sv
/*
  Regulator configuration bank: four 8-bit registers behind the serial
  register decoder, with decoded control outputs for the analog core.
  Assumes a decoder that presents one access per strobe, synchronous to mclk,
  and a sequencer that reports which of the four slots is powered.
*/
// What this block does
// - enable codes 0..3 pick sequencer slot
// - codes 4,5 force off; 6,7 force on
// - channel 2 mode bit: buck-boost or buck
// - discharge resistor when enabled bit, channel off
// - charging channel mode bit 7
// - drive trim 0 fastest, higher codes slower
// - charging peak limit 2.0/1.5/1.0/0.5 A
// - output peak limits 1.0/0.75/0.5/0.333 A
// - alternate voltage 25mV then 50mV steps
// - 0x7B 5.45V, 0x7C..0x7F give 5.5V
`timescale 1ns/1ps
`default_nettype none
module simreg_regs
  import simreg_pkg::*;
(
  input wire logic mclk, // 200 MHz clock
  input wire logic reset_n, // sync reset, active low
  input wire simreg_otp_t otp_image, // factory configuration store
  input wire logic [7:0] reg_addr, // register offset
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  input wire logic [3:0] seq_slot_on, // sequencer slots powered
  output logic [7:0] reg_rdata_q, // read data
  output logic reg_ack_q, // access done pulse
  output logic ch2_enable_q, // channel 2 running
  output logic ch2_discharge_q, // discharge resistor connected
  output logic ch2_buck_only_q, // channel 2 buck mode
  output logic charge_buck_only_q, // charging channel buck mode
  output logic [1:0] drive_trim_q, // shared drive strength
  output logic [11:0] charge_peak_ma_q, // charging limit, mA
  output logic [11:0] ch2_peak_ma_q, // channel 2 limit, mA
  output logic [11:0] ch1_peak_ma_q, // channel 1 limit, mA
  output logic [11:0] ch0_peak_ma_q, // channel 0 limit, mA
  output logic [12:0] ch0_alt_mv_q // channel 0 alternate target, mV
);

  function automatic logic [11:0] out_peak_ma(input logic [1:0] code);
    logic [11:0] ma;
    case (code)
      2'h0: ma = SIMREG_OUT_MA0;
      2'h1: ma = SIMREG_OUT_MA1;
      2'h2: ma = SIMREG_OUT_MA2;
      default: ma = SIMREG_OUT_MA3;
    endcase
    return ma;
  endfunction

  function automatic logic [11:0] chg_peak_ma(input logic [1:0] code);
    logic [11:0] ma;
    case (code)
      2'h0: ma = SIMREG_CHG_MA0;
      2'h1: ma = SIMREG_CHG_MA1;
      2'h2: ma = SIMREG_CHG_MA2;
      default: ma = SIMREG_CHG_MA3;
    endcase
    return ma;
  endfunction

  // register state
  simreg_ch2_ctrl_t ch2_ctrl_q, ch2_ctrl_d;
  simreg_top_cfg_t top_cfg_q, top_cfg_d;
  simreg_peak_lim_t peak_lim_q, peak_lim_d;
  simreg_alt_v_t alt_v_q, alt_v_d;
  logic [7:0] rdata_d;
  logic ack_d;

  // decoded outputs
  logic ch2_enable_d, ch2_discharge_d, ch2_buck_only_d, charge_buck_only_d;
  logic [1:0] drive_trim_d;
  logic [11:0] charge_peak_ma_d, ch2_peak_ma_d, ch1_peak_ma_d, ch0_peak_ma_d;
  logic [12:0] ch0_alt_mv_d;
  logic [12:0] alt_mv_w;

  simreg_vdecode u_vdecode (
    .code(alt_v_q.code),
    .millivolts(alt_mv_w)
  );

  // register file next state
  always_comb begin
    ch2_ctrl_d = ch2_ctrl_q;
    top_cfg_d = top_cfg_q;
    peak_lim_d = peak_lim_q;
    alt_v_d = alt_v_q;
    if (reg_wr) begin
      case (reg_addr)
        SIMREG_OFS_CH2_CTRL: begin
          ch2_ctrl_d = simreg_ch2_ctrl_t'(reg_wdata);
          ch2_ctrl_d.unused = SIMREG_UNUSED2_RST; // bits 5:4 not implemented
        end
        SIMREG_OFS_TOP_CFG: begin
          top_cfg_d = simreg_top_cfg_t'(reg_wdata);
          top_cfg_d.unused = SIMREG_UNUSED5_RST;
        end
        SIMREG_OFS_PEAK_LIM: begin
          peak_lim_d = simreg_peak_lim_t'(reg_wdata);
        end
        SIMREG_OFS_CH0_ALT_V: begin
          alt_v_d = simreg_alt_v_t'(reg_wdata);
        end
        default: begin
          ch2_ctrl_d = ch2_ctrl_q;
        end
      endcase
    end
  end

  // read path; a write in the same cycle is acknowledged too
  always_comb begin
    rdata_d = 8'h00;
    ack_d = reg_wr | reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        SIMREG_OFS_CH2_CTRL: rdata_d = ch2_ctrl_q;
        SIMREG_OFS_TOP_CFG: rdata_d = top_cfg_q;
        SIMREG_OFS_PEAK_LIM: rdata_d = peak_lim_q;
        SIMREG_OFS_CH0_ALT_V: rdata_d = alt_v_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // decode of control outputs
  always_comb begin
    case (ch2_ctrl_q.slot_select)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        ch2_enable_d = seq_slot_on[ch2_ctrl_q.slot_select[1:0]];
      end
      3'h4, 3'h5: ch2_enable_d = 1'b0;
      3'h6, 3'h7: ch2_enable_d = 1'b1;
      default: ch2_enable_d = 1'b0;
    endcase
    ch2_discharge_d = ch2_ctrl_q.discharge_on & ~ch2_enable_d;
    ch2_buck_only_d = ch2_ctrl_q.buck_only;
    charge_buck_only_d = top_cfg_q.charge_buck_only;
    drive_trim_d = top_cfg_q.drive_trim;
    charge_peak_ma_d = chg_peak_ma(peak_lim_q.charge);
    ch2_peak_ma_d = out_peak_ma(peak_lim_q.ch2);
    ch1_peak_ma_d = out_peak_ma(peak_lim_q.ch1);
    ch0_peak_ma_d = out_peak_ma(peak_lim_q.ch0);
    ch0_alt_mv_d = alt_mv_w;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ch2_ctrl_q <= otp_image.ch2_ctrl;
      ch2_ctrl_q.reserved_bit <= SIMREG_RESERVED_RST;
      ch2_ctrl_q.unused <= SIMREG_UNUSED2_RST;
      top_cfg_q <= otp_image.top_cfg;
      top_cfg_q.unused <= SIMREG_UNUSED5_RST;
      peak_lim_q <= otp_image.peak_lim;
      alt_v_q <= otp_image.alt_v;
      alt_v_q.reserved_bit <= SIMREG_RESERVED_RST;
      reg_rdata_q <= 8'h00;
      reg_ack_q <= 1'b0;
    end else begin
      ch2_ctrl_q <= ch2_ctrl_d;
      top_cfg_q <= top_cfg_d;
      peak_lim_q <= peak_lim_d;
      alt_v_q <= alt_v_d;
      reg_rdata_q <= rdata_d;
      reg_ack_q <= ack_d;
    end
  end

  // outputs follow the registers one cycle later
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ch2_enable_q <= 1'b0;
      ch2_discharge_q <= 1'b0;
      ch2_buck_only_q <= 1'b0;
      charge_buck_only_q <= 1'b0;
      drive_trim_q <= 2'h0;
      charge_peak_ma_q <= 12'h000;
      ch2_peak_ma_q <= 12'h000;
      ch1_peak_ma_q <= 12'h000;
      ch0_peak_ma_q <= 12'h000;
      ch0_alt_mv_q <= 13'h0000;
    end else begin
      ch2_enable_q <= ch2_enable_d;
      ch2_discharge_q <= ch2_discharge_d;
      ch2_buck_only_q <= ch2_buck_only_d;
      charge_buck_only_q <= charge_buck_only_d;
      drive_trim_q <= drive_trim_d;
      charge_peak_ma_q <= charge_peak_ma_d;
      ch2_peak_ma_q <= ch2_peak_ma_d;
      ch1_peak_ma_q <= ch1_peak_ma_d;
      ch0_peak_ma_q <= ch0_peak_ma_d;
      ch0_alt_mv_q <= ch0_alt_mv_d;
    end
  end

  AST_CH2_SLOT_FOLLOWS: assert property (@(posedge mclk) disable iff (!reset_n)
    (ch2_ctrl_q.slot_select <= SIMREG_EN_SLOT_MAX)
    |=> (ch2_enable_q == $past(seq_slot_on[ch2_ctrl_q.slot_select[1:0]])))
    else $error("channel 2 enable does not follow its sequencer slot");

  AST_CH2_FORCED: assert property (@(posedge mclk) disable iff (!reset_n)
    (ch2_ctrl_q.slot_select > SIMREG_EN_SLOT_MAX)
    |=> (ch2_enable_q == ($past(ch2_ctrl_q.slot_select) >= SIMREG_EN_FORCE_ON_MIN)))
    else $error("channel 2 forced state wrong");

  AST_CH2_MODE_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_CH2_CTRL)
    |=> ##1 (ch2_buck_only_q == $past(reg_wdata[SIMREG_CH2_MODE_POS], 2)))
    else $error("channel 2 mode not taken from bit 6");

  AST_CH2_DISCHARGE: assert property (@(posedge mclk) disable iff (!reset_n)
    ch2_discharge_q |-> (!ch2_enable_q && $past(ch2_ctrl_q.discharge_on)))
    else $error("discharge resistor connected while channel on or disabled");

  AST_CHG_MODE_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_TOP_CFG)
    |=> ##1 (charge_buck_only_q == $past(reg_wdata[SIMREG_TOP_CHGMODE_POS], 2)))
    else $error("charging channel mode not taken from bit 7");

  AST_DRIVE_TRIM: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_TOP_CFG)
    |=> ##1 (drive_trim_q == $past(reg_wdata[SIMREG_TOP_DRV_LSB +: 2], 2)))
    else $error("drive trim not taken from bits 1:0");

  AST_CHG_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_PEAK_LIM && reg_wdata[7:6] == 2'h3)
    |=> ##1 (charge_peak_ma_q == 12'h1f4))
    else $error("charging limit code 3 is not 500 mA");

  AST_CH0_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_PEAK_LIM && reg_wdata[1:0] == 2'h1)
    |=> ##1 (ch0_peak_ma_q == 12'h2ee))
    else $error("channel 0 limit code 1 is not 750 mA");

  AST_ALT_KNEE: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_CH0_ALT_V && reg_wdata[6:0] == 7'h30)
    |=> ##1 (ch0_alt_mv_q == 13'h06a4))
    else $error("code 0x30 is not 1700 mV");

  AST_ALT_CLAMP: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_CH0_ALT_V && reg_wdata[6:0] >= 7'h7b)
    |=> ##1 (ch0_alt_mv_q == ($past(reg_wdata[6:0], 2) == 7'h7b ? 13'h154a : 13'h157c)))
    else $error("top alternate voltage codes decode wrong");

  AST_RESET_LOAD: assert property (@(posedge mclk)
    $rose(reset_n) |-> (peak_lim_q == $past(otp_image.peak_lim)
      && alt_v_q.reserved_bit == 1'b0 && ch2_ctrl_q.reserved_bit == 1'b0))
    else $error("reset did not load factory image");

  AST_READ_ACK: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd && reg_addr == SIMREG_OFS_PEAK_LIM && !reg_wr)
    |=> (reg_ack_q && reg_rdata_q == $past(peak_lim_q)))
    else $error("read of peak limits wrong");

  AST_ACK_FOLLOWS: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr || reg_rd)
    |=> reg_ack_q)
    else $error("access strobe not acknowledged");

  AST_ACK_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
    !(reg_wr || reg_rd)
    |=> !reg_ack_q)
    else $error("acknowledge without an access");

  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_rd
    |=> (reg_rdata_q == 8'h00))
    else $error("read data not zero outside a read");

  AST_CH2_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_PEAK_LIM && reg_wdata[5:4] == 2'h3)
    |=> ##1 (ch2_peak_ma_q == 12'h14d))
    else $error("channel 2 limit code 3 is not 333 mA");

  AST_CH1_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_PEAK_LIM && reg_wdata[3:2] == 2'h2)
    |=> ##1 (ch1_peak_ma_q == 12'h1f4))
    else $error("channel 1 limit code 2 is not 500 mA");

  AST_CHG_LIMIT_TOP: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_PEAK_LIM && reg_wdata[7:6] == 2'h0)
    |=> ##1 (charge_peak_ma_q == 12'h7d0))
    else $error("charging limit code 0 is not 2000 mA");

  AST_ALT_FINE: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == SIMREG_OFS_CH0_ALT_V && reg_wdata[6:0] == 7'h2f)
    |=> ##1 (ch0_alt_mv_q == 13'h068b))
    else $error("code 0x2f is not 1675 mV");

  AST_CH2_DISCH_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(reset_n) && !ch2_enable_q && $past(ch2_ctrl_q.discharge_on))
    |-> ch2_discharge_q)
    else $error("discharge resistor missing while channel off");

  AST_RESET_QUIET: assert property (@(posedge mclk)
    $rose(reset_n) |-> (!reg_ack_q && reg_rdata_q == 8'h00 && !ch2_enable_q
      && !ch2_discharge_q && ch0_alt_mv_q == 13'h0000))
    else $error("outputs not quiet at reset release");

endmodule
`default_nettype wire

// ===== tb_simo_regulator_config_regs.sv
/*
  Self-checking bench for the regulator configuration bank.
  Assumes simreg_pkg and simreg_regs are compiled first; bench drives the
  strobe port at the falling edge and keeps a shadow of all four registers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_simo_regulator_config_regs
  import simreg_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  simreg_otp_t otp_image = '0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [3:0] seq_slot_on = 4'h0;
  logic [7:0] reg_rdata_q;
  logic reg_ack_q;
  logic ch2_enable_q, ch2_discharge_q, ch2_buck_only_q, charge_buck_only_q;
  logic [1:0] drive_trim_q;
  logic [11:0] charge_peak_ma_q, ch2_peak_ma_q, ch1_peak_ma_q, ch0_peak_ma_q;
  logic [12:0] ch0_alt_mv_q;
  integer seed = 32'hf978;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] exp_q[$];
  logic [7:0] sh [4];
  logic [7:0] ofs [4] = '{8'h2e, 8'h2f, 8'h30, 8'h31};
  logic [7:0] msk [4] = '{8'h4f, 8'h83, 8'hff, 8'h7f};
  logic [6:0] vcodes [8] = '{7'h00, 7'h2f, 7'h30, 7'h31, 7'h7b, 7'h7c, 7'h7d, 7'h7f};

  simreg_regs DUT (.mclk(mclk), .reset_n(reset_n), .otp_image(otp_image),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .seq_slot_on(seq_slot_on), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .ch2_enable_q(ch2_enable_q), .ch2_discharge_q(ch2_discharge_q),
    .ch2_buck_only_q(ch2_buck_only_q), .charge_buck_only_q(charge_buck_only_q),
    .drive_trim_q(drive_trim_q), .charge_peak_ma_q(charge_peak_ma_q),
    .ch2_peak_ma_q(ch2_peak_ma_q), .ch1_peak_ma_q(ch1_peak_ma_q),
    .ch0_peak_ma_q(ch0_peak_ma_q), .ch0_alt_mv_q(ch0_alt_mv_q));

  always #2.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [12:0] out_ma(input logic [1:0] c);
    case (c)
      2'h0: out_ma = 13'h3e8;
      2'h1: out_ma = 13'h2ee;
      2'h2: out_ma = 13'h1f4;
      default: out_ma = 13'h14d;
    endcase
  endfunction

  function automatic logic [12:0] vmv(input logic [6:0] c);
    if (c < 7'h30) vmv = 13'h1f4 + 13'h19 * c;
    else if (c < 7'h7c) vmv = 13'h6a4 + 13'h32 * (c - 7'h30);
    else vmv = 13'h157c;
  endfunction

  // one strobe cycle; the note is taken before the shadow moves
  task automatic acc(input logic [7:0] a, input logic rd, input logic wr,
                     input logic [7:0] d);
    int k;
    k = -1;
    for (int i = 0; i < 4; i++) if (ofs[i] === a) k = i;
    reg_addr = a;
    reg_rd = rd;
    reg_wr = wr;
    reg_wdata = d;
    if (rd || wr) exp_q.push_back((rd && k >= 0) ? sh[k] : 8'h00);
    if (wr && k >= 0) sh[k] = d & msk[k];
    @(negedge mclk);
  endtask

  task automatic idle();
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic chk_all();
    logic en;
    en = (sh[0][2:0] <= 3'h3) ? seq_slot_on[sh[0][1:0]] : sh[0][1];
    chk("ch2_enable_q", en, ch2_enable_q);
    chk("ch2_discharge_q", sh[0][3] & ~en, ch2_discharge_q);
    chk("ch2_buck_only_q", sh[0][6], ch2_buck_only_q);
    chk("charge_buck_only_q", sh[1][7], charge_buck_only_q);
    chk("drive_trim_q", sh[1][1:0], drive_trim_q);
    chk("charge_peak_ma_q", 13'h7d0 - 13'h1f4 * sh[2][7:6], charge_peak_ma_q);
    chk("ch2_peak_ma_q", out_ma(sh[2][5:4]), ch2_peak_ma_q);
    chk("ch1_peak_ma_q", out_ma(sh[2][3:2]), ch1_peak_ma_q);
    chk("ch0_peak_ma_q", out_ma(sh[2][1:0]), ch0_peak_ma_q);
    chk("ch0_alt_mv_q", vmv(sh[3][6:0]), ch0_alt_mv_q);
  endtask

  // write, read back at once, then check the decoded outputs
  task automatic put(input int i, input logic [7:0] d);
    acc(ofs[i], 1'b0, 1'b1, d);
    acc(ofs[i], 1'b1, 1'b0, 8'h00);
    idle();
    @(negedge mclk);
    chk_all();
  endtask

  always @(negedge mclk) begin
    if (reset_n === 1'b1 && reg_ack_q === 1'b1) begin
      if (exp_q.size() == 0) chk("reg_ack_q", 13'h0, 13'h1);
      else chk("reg_rdata_q", exp_q.pop_front(), reg_rdata_q);
    end else if (reset_n === 1'b1) begin
      chk("reg_rdata_q idle", 13'h0, reg_rdata_q);
    end
  end

  initial begin
    #50000;
    n_errors++;
    wrap_up();
  end

  initial begin
    logic [1:0] a;
    otp_image = $random(seed);
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) sh[i] = otp_image[31-8*i -: 8] & msk[i];
    for (int i = 0; i < 4; i++) acc(ofs[i], 1'b1, 1'b0, 8'h00);
    idle();
    chk_all();
    for (int k = 0; k < 16; k++) begin
      seq_slot_on = 4'($random(seed));
      // bit 7 kept zero, unused bits set to show they are dropped
      put(0, {1'b0, 1'($random(seed)), 2'h3, k[3], k[2:0]});
      seq_slot_on = ~seq_slot_on;
      repeat (2) @(negedge mclk);
      chk_all();
    end
    for (int k = 0; k < 8; k++) put(1, {k[2], 5'h1f, k[1:0]});
    for (int c = 0; c < 8; c++) begin
      a = c[1:0];
      if (c < 4) put(2, {a, a + 2'h1, a + 2'h2, a + 2'h3});
      else put(2, 8'($random(seed)));
    end
    for (int k = 0; k < 16; k++)
      put(3, {1'b0, (k < 8) ? vcodes[k] : 7'($random(seed))});
    acc(8'h2d, 1'b1, 1'b1, 8'hff);
    acc(8'h32, 1'b1, 1'b1, 8'hff);
    acc(ofs[3], 1'b1, 1'b1, 8'h45);
    for (int i = 0; i < 4; i++) acc(ofs[i], 1'b1, 1'b0, 8'h00);
    for (int k = 0; k < 24; k++) begin
      a = 2'($random(seed));
      seq_slot_on = 4'($random(seed));
      acc(ofs[a], 1'($random(seed)), 1'($random(seed)), 8'($random(seed)) & 8'h7f);
    end
    idle();
    repeat (2) @(negedge mclk);
    chk_all();
    chk("pending acks", 13'h0, 13'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
